// ---- pkg/cs_pkg.sv ----
`default_nettype none
package cs_pkg;
    // Timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int CLK_MHZ        = 1000 / CLK_PERIOD_NS;
    localparam int MAX_SYS_MHZ    = 32;
    localparam int TICK2X_MIN_CYC = (CLK_MHZ + 2 * MAX_SYS_MHZ - 1) / (2 * MAX_SYS_MHZ);
    localparam int GAP_W          = 3;
    localparam logic [GAP_W-1:0] GAP_OK_CNT = GAP_W'(TICK2X_MIN_CYC - 1);
    localparam int REF_LOSS_NS    = 2000;
    localparam int REF_LOSS_CYC   = REF_LOSS_NS / CLK_PERIOD_NS;
    localparam int LOSS_W         = $clog2(REF_LOSS_CYC + 1);
    localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(REF_LOSS_CYC);
    // VCO ticks at 24x ref: /3 gives the 8x of the 2X path, /2 the 3X path
    localparam logic [7:0] VCO_PER_2X    = 8'h03;
    localparam logic [7:0] VCO_PER_3X    = 8'h02;
    localparam logic [2:0] POST_MAX_CODE = 3'h5;
    localparam logic [7:0] POST_MAX_DIV  = 8'h20;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_DIVBY = 8'h04;
    localparam logic [7:0] ADDR_STAT  = 8'h08;
    localparam logic [7:0] ADDR_MASK  = 8'h0C;
    localparam logic [7:0] ADDR_OSC   = 8'h10;
    localparam logic [7:0] ADDR_FOPT  = 8'h14;
    // Fields
    localparam int CTRL_W = 5;
    localparam int CTRL_REF_SEL  = 0;
    localparam int CTRL_PLL_SEL  = 1;
    localparam int CTRL_PLL_PD   = 2;
    localparam int CTRL_EXT_MODE = 3;
    localparam int CTRL_SHDN_EN  = 4;
    localparam int TRIM_W = 10;
    localparam int OSC_W  = 13;
    localparam int OSC_RELAX_PD   = 10;
    localparam int OSC_RELAX_STBY = 11;
    localparam int OSC_CRYSTAL_OUT_PIN_PD    = 12;
    localparam int EV_W = 3;
    localparam int EV_LOCK    = 0;
    localparam int EV_UNLOCK  = 1;
    localparam int EV_REFLOSS = 2;
    localparam int STAT_LIVE_LSB = 8;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
    localparam logic [2:0]        DIVBY_RST = 3'h0;
    localparam logic [OSC_W-1:0]  OSC_RST   = 13'h0000;
    localparam logic [EV_W-1:0]   MASK_RST  = 3'h0;
    localparam logic [TRIM_W-1:0] FOPT_RST  = 10'h000;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CS_BYP = 3'b001,
        CS_PLL = 3'b010,
        CS_OFF = 3'b100
    } cs_path_t;
endpackage
`default_nettype wire

// ---- pkg/cs_reg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cs_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_err, rd_data, rd_err);
    modport core (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// ---- hw/cs_axil_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module cs_axil_slave
    import cs_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    cs_reg_if.bus            regs
);
    logic        aw_h, w_h, next_aw_h, next_w_h;
    logic [7:0]  aw_a, next_aw_a;
    logic [31:0] w_d, next_w_d;
    logic [3:0]  w_s, next_w_s;
    logic        next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // Write fires once both halves are held, one cycle after the later one
    assign regs.wr_en   = aw_h & w_h & ~s_axi_bvalid_out;
    assign regs.wr_addr = aw_a;
    assign regs.wr_data = w_d;
    assign regs.wr_strb = w_s;
    assign regs.rd_addr = s_axi_araddr_in;

    always_comb begin
        next_aw_h = aw_h;
        next_aw_a = aw_a;
        next_w_h = w_h;
        next_w_d = w_d;
        next_w_s = w_s;
        next_bvalid = s_axi_bvalid_out;
        next_bresp = s_axi_bresp_out;
        next_rvalid = s_axi_rvalid_out;
        next_rdata = s_axi_rdata_out;
        next_rresp = s_axi_rresp_out;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_aw_h = 1'b1;
            next_aw_a = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_w_h = 1'b1;
            next_w_d = s_axi_wdata_in;
            next_w_s = s_axi_wstrb_in;
        end
        if (regs.wr_en) begin
            next_aw_h = 1'b0;
            next_w_h = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = regs.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next_rvalid = 1'b1;
            next_rdata = regs.rd_data;
            next_rresp = regs.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        next_awready = ~next_aw_h;
        next_wready = ~next_w_h;
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_h <= 1'b0;
            aw_a <= 8'h00;
            w_h <= 1'b0;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_arready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end else begin
            aw_h <= next_aw_h;
            aw_a <= next_aw_a;
            w_h <= next_w_h;
            w_d <= next_w_d;
            w_s <= next_w_s;
            s_axi_awready_out <= next_awready;
            s_axi_wready_out <= next_wready;
            s_axi_arready_out <= next_arready;
            s_axi_bvalid_out <= next_bvalid;
            s_axi_bresp_out <= next_bresp;
            s_axi_rvalid_out <= next_rvalid;
            s_axi_rdata_out <= next_rdata;
            s_axi_rresp_out <= next_rresp;
        end
    end
endmodule // cs_axil_slave
`default_nettype wire

// ---- hw/cs_clock_synth.sv ----
`timescale 1ns/1ps
`default_nettype none
module cs_clock_synth
    import cs_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              resetn_in,
    input  wire logic [7:0]        s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [7:0]        s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    input  wire logic              relax_osc_in,
    input  wire logic              crystal_in_pin_in,
    input  wire logic              ext_clock_pin_in,
    input  wire logic              pll_vco_tick_in,
    input  wire logic              pll_lock_in,
    input  wire logic [TRIM_W-1:0] flash_trim_in,
    output logic                   clk2x_tick_out,
    output logic                   clk3x_tick_out,
    output logic                   sys_clk_out,
    output logic [TRIM_W-1:0]      osc_trim_out,
    output logic                   relax_pd_out,
    output logic                   relax_stby_out,
    output logic                   crystal_out_pin_pd_out,
    output logic                   pll_pd_out,
    output logic                   shutdown_out,
    output logic                   irq_out
);
    cs_reg_if regs ();

    cs_axil_slave u_slave (
        .sys_clk_in        (sys_clk_in),
        .resetn_in         (resetn_in),
        .s_axi_awaddr_in   (s_axi_awaddr_in),
        .s_axi_awvalid_in  (s_axi_awvalid_in),
        .s_axi_awready_out (s_axi_awready_out),
        .s_axi_wdata_in    (s_axi_wdata_in),
        .s_axi_wstrb_in    (s_axi_wstrb_in),
        .s_axi_wvalid_in   (s_axi_wvalid_in),
        .s_axi_wready_out  (s_axi_wready_out),
        .s_axi_bresp_out   (s_axi_bresp_out),
        .s_axi_bvalid_out  (s_axi_bvalid_out),
        .s_axi_bready_in   (s_axi_bready_in),
        .s_axi_araddr_in   (s_axi_araddr_in),
        .s_axi_arvalid_in  (s_axi_arvalid_in),
        .s_axi_arready_out (s_axi_arready_out),
        .s_axi_rdata_out   (s_axi_rdata_out),
        .s_axi_rresp_out   (s_axi_rresp_out),
        .s_axi_rvalid_out  (s_axi_rvalid_out),
        .s_axi_rready_in   (s_axi_rready_in),
        .regs              (regs)
    );

    // Register state
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [2:0]        divby, next_divby;
    logic [OSC_W-1:0]  osc, next_osc;
    logic [EV_W-1:0]   mask, next_mask;
    logic [EV_W-1:0]   stat, next_stat;
    logic [TRIM_W-1:0] fopt, next_fopt;
    logic              fopt_loaded;
    logic [31:0]       wv;
    logic [EV_W-1:0]   ev, clr;
    // Path state
    cs_path_t          state, next_state;
    logic              ref_q, ref_lvl, ref_rise, lock_q;
    logic [LOSS_W-1:0] loss_cnt, next_loss_cnt;
    logic              ref_lost;
    logic [7:0]        cnt2, next_cnt2, cnt3, next_cnt3;
    logic [7:0]        post, term2, term3;
    logic [2:0]        code;
    logic              cand2, cand3, cand, gap_ok;
    logic [GAP_W-1:0]  gap_cnt, next_gap_cnt;
    logic              next_tick2, next_tick3, next_sys;

    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Read decode, unmapped offsets answer with an error
    always_comb begin
        regs.rd_err = 1'b0;
        case (regs.rd_addr)
            ADDR_CTRL: regs.rd_data = {27'h0, ctrl};
            ADDR_DIVBY: regs.rd_data = {29'h0, divby};
            ADDR_STAT: regs.rd_data = {21'h0, shutdown_out, state == CS_PLL,
                                       pll_lock_in, 5'h00, stat};
            ADDR_MASK: regs.rd_data = {29'h0, mask};
            ADDR_OSC: regs.rd_data = {19'h0, osc};
            ADDR_FOPT: regs.rd_data = {22'h0, fopt};
            default: begin
                regs.rd_data = 32'h0000_0000;
                regs.rd_err = 1'b1;
            end
        endcase
    end

    // Events: PLL lock gained, lock lost, reference lost
    assign ev[EV_LOCK] = pll_lock_in & ~lock_q;
    assign ev[EV_UNLOCK] = ~pll_lock_in & lock_q;
    assign ev[EV_REFLOSS] = (next_loss_cnt == LOSS_LAST) & ~ref_lost;

    always_comb begin
        next_ctrl = ctrl;
        next_divby = divby;
        next_osc = osc;
        next_mask = mask;
        next_fopt = fopt;
        clr = '0;
        regs.wr_err = 1'b0;
        wv = 32'h0000_0000;
        if (!fopt_loaded) begin
            next_fopt = flash_trim_in;
        end
        case (regs.wr_addr)
            ADDR_CTRL: begin
                wv = wmerge({27'h0, ctrl}, regs.wr_data, regs.wr_strb);
                if (regs.wr_en) next_ctrl = wv[CTRL_W-1:0];
            end
            ADDR_DIVBY: begin
                wv = wmerge({29'h0, divby}, regs.wr_data, regs.wr_strb);
                if (regs.wr_en) next_divby = wv[2:0];
            end
            ADDR_STAT: begin
                if (regs.wr_en && regs.wr_strb[0]) clr = regs.wr_data[EV_W-1:0];
            end
            ADDR_MASK: begin
                wv = wmerge({29'h0, mask}, regs.wr_data, regs.wr_strb);
                if (regs.wr_en) next_mask = wv[EV_W-1:0];
            end
            ADDR_OSC: begin
                wv = wmerge({19'h0, osc}, regs.wr_data, regs.wr_strb);
                if (regs.wr_en) next_osc = wv[OSC_W-1:0];
            end
            ADDR_FOPT: ;
            default: regs.wr_err = 1'b1;
        endcase
        // Set beats clear so an event in the clearing cycle is kept
        next_stat = (stat & ~clr) | ev;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl <= CTRL_RST;
            divby <= DIVBY_RST;
            osc <= OSC_RST;
            mask <= MASK_RST;
            stat <= '0;
            fopt <= FOPT_RST;
            fopt_loaded <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            divby <= next_divby;
            osc <= next_osc;
            mask <= next_mask;
            stat <= next_stat;
            fopt <= next_fopt;
            fopt_loaded <= 1'b1;
        end
    end

    // Reference selection; internal unless the select bit is set
    assign ref_lvl = ~ctrl[CTRL_REF_SEL] ? relax_osc_in :
                     (ctrl[CTRL_EXT_MODE] ? ext_clock_pin_in : crystal_in_pin_in);
    assign ref_rise = ref_lvl & ~ref_q;
    assign ref_lost = loss_cnt == LOSS_LAST;

    assign code = (divby > POST_MAX_CODE) ? POST_MAX_CODE : divby;
    assign post = 8'h01 << code;
    assign term2 = 8'(VCO_PER_2X * post);
    assign term3 = 8'(VCO_PER_3X * post);
    assign gap_ok = gap_cnt >= GAP_OK_CNT;

    always_comb begin
        next_loss_cnt = ref_rise ? '0 : (ref_lost ? loss_cnt : loss_cnt + 1'b1);
        next_cnt2 = cnt2;
        next_cnt3 = cnt3;
        cand2 = 1'b0;
        cand3 = 1'b0;
        // PLL divide to 8x ref (2X) and 12x ref (3X) / postscaler
        if (pll_vco_tick_in) begin
            if (cnt2 >= term2 - 8'h01) begin
                next_cnt2 = 8'h00;
                cand2 = 1'b1;
            end else begin
                next_cnt2 = cnt2 + 8'h01;
            end
            if (cnt3 >= term3 - 8'h01) begin
                next_cnt3 = 8'h00;
                cand3 = 1'b1;
            end else begin
                next_cnt3 = cnt3 + 8'h01;
            end
        end
        case (state)
            CS_BYP: cand = ref_rise;
            CS_PLL: cand = cand2;
            default: cand = 1'b0;
        endcase
        next_tick2 = cand & gap_ok;
        // 3X tick from the PLL only
        next_tick3 = cand3 & (state == CS_PLL);
        next_sys = sys_clk_out ^ next_tick2;
        next_gap_cnt = next_tick2 ? '0 : (gap_ok ? gap_cnt : gap_cnt + 1'b1);
        next_state = state;
        case (state)
            // Switch between bypass and PLL only once the minimum 2X tick gap has passed
            CS_BYP: begin
                if (ctrl[CTRL_PLL_SEL] && pll_lock_in && !ctrl[CTRL_PLL_PD] && gap_ok) begin
                    next_state = CS_PLL;
                end
            end
            CS_PLL: begin
                if (ref_lost && ctrl[CTRL_SHDN_EN]) begin
                    next_state = CS_OFF;
                end else if ((!ctrl[CTRL_PLL_SEL] || !pll_lock_in || ctrl[CTRL_PLL_PD])
                             && gap_ok) begin
                    next_state = CS_BYP;
                end
            end
            CS_OFF: begin
                if (!stat[EV_REFLOSS]) next_state = CS_BYP;
            end
            default: next_state = CS_BYP;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= CS_BYP;
            ref_q <= 1'b0;
            lock_q <= 1'b0;
            loss_cnt <= '0;
            cnt2 <= 8'h00;
            cnt3 <= 8'h00;
            gap_cnt <= '0;
            clk2x_tick_out <= 1'b0;
            clk3x_tick_out <= 1'b0;
            sys_clk_out <= 1'b0;
        end else begin
            state <= next_state;
            ref_q <= ref_lvl;
            lock_q <= pll_lock_in;
            loss_cnt <= next_loss_cnt;
            cnt2 <= next_cnt2;
            cnt3 <= next_cnt3;
            gap_cnt <= next_gap_cnt;
            clk2x_tick_out <= next_tick2;
            clk3x_tick_out <= next_tick3;
            sys_clk_out <= next_sys;
        end
    end

    // Control outputs to the analog side
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            osc_trim_out <= '0;
            relax_pd_out <= 1'b0;
            relax_stby_out <= 1'b0;
            crystal_out_pin_pd_out <= 1'b0;
            pll_pd_out <= 1'b0;
            shutdown_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            osc_trim_out <= osc[TRIM_W-1:0];
            relax_pd_out <= osc[OSC_RELAX_PD];
            relax_stby_out <= osc[OSC_RELAX_STBY];
            crystal_out_pin_pd_out <= osc[OSC_CRYSTAL_OUT_PIN_PD];
            pll_pd_out <= next_ctrl[CTRL_PLL_PD] | (next_state == CS_OFF);
            shutdown_out <= next_state == CS_OFF;
            irq_out <= |(next_stat & next_mask);
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence shut_seq;
        shutdown_out ##0 pll_pd_out ##1 !clk2x_tick_out;
    endsequence

    pll_div_a: assert property (
        (state == CS_PLL && cand2 && gap_ok) |=> clk2x_tick_out)
        else $error("PLL tick not passed to 2X output");
    byp_rate_a: assert property (
        (state == CS_BYP && ref_rise && gap_ok) |=> clk2x_tick_out)
        else $error("Bypass reference edge not passed to 2X output");
    sys_half_a: assert property (
        clk2x_tick_out == (sys_clk_out != $past(sys_clk_out)))
        else $error("System clock not toggling once per 2X tick");
    three_x_a: assert property (
        clk3x_tick_out |-> $past(state) == CS_PLL)
        else $error("3X tick outside PLL path");
    gap_2x_a: assert property (
        clk2x_tick_out |=> !clk2x_tick_out [*3])
        else $error("2X ticks closer than four cycles");
    ref_reset_a: assert property (
        !fopt_loaded |-> (ctrl == CTRL_RST && state == CS_BYP))
        else $error("Reference not internal after reset");
    trim_drive_a: assert property (
        $changed(osc[TRIM_W-1:0]) |=> osc_trim_out == $past(osc[TRIM_W-1:0]))
        else $error("Trim output not following trim field");
    flash_load_a: assert property (
        $rose(fopt_loaded) |-> fopt == $past(flash_trim_in))
        else $error("Factory trim not captured after reset");
    osc_power_a: assert property (
        (osc[OSC_RELAX_PD] && osc[OSC_RELAX_STBY]) |=> (relax_pd_out && relax_stby_out))
        else $error("Oscillator power controls not driven");
    pll_power_a: assert property (
        ctrl[CTRL_PLL_PD] |-> ##[0:4] (state != CS_PLL))
        else $error("PLL path kept while PLL powered down");
    safety_shut_a: assert property (
        (state == CS_PLL && ref_lost && ctrl[CTRL_SHDN_EN]) |=> shut_seq)
        else $error("No shutdown on lost reference");
    post_map_a: assert property (
        (divby > POST_MAX_CODE) |-> post == POST_MAX_DIV)
        else $error("Spare postscaler code not dividing by 32");
    clean_switch_a: assert property (
        ($past(state) == CS_BYP && state == CS_PLL) |-> $past(gap_ok))
        else $error("Path switched inside a tick gap");
endmodule // cs_clock_synth
`default_nettype wire

// ---- verification/cs_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cs_osc_model (
    input  wire logic clk_in,
    input  wire logic lock_en_in,
    input  wire logic crystal_out_pin_pd_in,
    output logic      relax_out,
    output logic      crystal_out_pin_out,
    output logic      ext_out,
    output logic      vco_tick_out,
    output logic      lock_out
);
    logic [2:0] cnt = 3'h0;
    // Behavioural: relax and crystal ref period 8 cycles, external 4, VCO tick every 2nd cycle
    always @(posedge clk_in) begin
        cnt <= cnt + 3'h1;
        relax_out <= cnt[2];
        crystal_out_pin_out <= cnt[2] & ~crystal_out_pin_pd_in;
        ext_out <= cnt[1];
        vco_tick_out <= cnt[0];
        lock_out <= lock_en_in;
    end
endmodule // cs_osc_model
`default_nettype wire

// ---- verification/test_clock_synthesis_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_clock_synthesis_control import cs_pkg::*; ;
    logic sys_clk_in = 1'b0, resetn_in = 1'b0, lock_en = 1'b0;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic crystal_in_pin_in, ext_clock_pin_in;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic [9:0] flash_trim_in = 10'h000, osc_trim_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic relax_osc_in, pll_vco_tick_in, pll_lock_in, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, clk2x_tick_out;
    logic clk3x_tick_out, sys_clk_out, relax_pd_out, relax_stby_out;
    logic crystal_out_pin_pd_out, pll_pd_out, shutdown_out, irq_out;
    logic [33:0] q[$];
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    cs_clock_synth dut (.*);
    cs_osc_model osc (.clk_in(sys_clk_in), .lock_en_in(lock_en), .crystal_out_pin_pd_in(crystal_out_pin_pd_out),
        .relax_out(relax_osc_in), .crystal_out_pin_out(crystal_in_pin_in), .ext_out(ext_clock_pin_in),
        .vco_tick_out(pll_vco_tick_in), .lock_out(pll_lock_in));
    task automatic end_sim();
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (s_axi_bvalid_out) chk(q.pop_front(), {s_axi_bresp_out, 32'h0});
        if (s_axi_rvalid_out) chk(q.pop_front(), {s_axi_rresp_out, s_axi_rdata_out});
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({r, 32'h0});
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do @(posedge sys_clk_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge sys_clk_in); while (!s_axi_rvalid_out);
    endtask
    function automatic logic tk(input bit s);
        return s ? clk3x_tick_out : clk2x_tick_out;
    endfunction
    // Skips two ticks so a divider change settles first
    task automatic gap(input bit s, input int e);
        int n;
        logic v;
        n = 0;
        repeat (2) do @(posedge sys_clk_in); while (!tk(s));
        v = sys_clk_out;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (!tk(s));
        chk(34'(e), 34'(n));
        if (!s) chk(34'(!v), 34'(sys_clk_out));
    endtask
    initial begin
        void'($urandom(919));
        flash_trim_in = 10'($urandom);
        repeat (20) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        @(posedge sys_clk_in);
        rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
        rd(ADDR_FOPT, {RESP_OKAY, 22'h0, flash_trim_in});
        wr(ADDR_OSC, {22'h0, flash_trim_in}, RESP_OKAY);
        rd(ADDR_OSC, {RESP_OKAY, 22'h0, flash_trim_in});
        chk(34'(flash_trim_in), 34'(osc_trim_out));
        rd(8'h3C, {RESP_SLVERR, 32'h0});
        gap(1'b0, 8);
        lock_en <= 1'b1;
        wr(ADDR_MASK, 32'h1, RESP_OKAY);
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_DIVBY, 32'(c), RESP_OKAY);
            gap(1'b0, 6 * (c > 5 ? 32 : 1 << c));
        end
        gap(1'b1, 128);
        chk(34'h1, 34'(irq_out));
        wr(ADDR_STAT, 32'h1, RESP_OKAY);
        repeat (2) @(posedge sys_clk_in);
        chk(34'h0, 34'(irq_out));
        // Running external pin keeps the PLL path alive
        wr(ADDR_CTRL, 32'h1B, RESP_OKAY);
        repeat (450) @(posedge sys_clk_in);
        rd(ADDR_STAT, {RESP_OKAY, 32'h300});
        // Crystal as reference, then both oscillators powered down
        wr(ADDR_CTRL, 32'h13, RESP_OKAY);
        wr(ADDR_OSC, 32'h1400, RESP_OKAY);
        repeat (450) @(posedge sys_clk_in);
        chk(34'h1, 34'(shutdown_out));
        rd(ADDR_STAT, {RESP_OKAY, 32'h504});
        wr(ADDR_CTRL, 32'h4, RESP_OKAY);
        wr(ADDR_OSC, 32'h1C00, RESP_OKAY);
        repeat (2) @(posedge sys_clk_in);
        chk(34'hF, 34'({relax_pd_out, relax_stby_out, crystal_out_pin_pd_out, pll_pd_out}));
        end_sim();
    end
endmodule // test_clock_synthesis_control
`default_nettype wire
